// ---- mas_fabric_sink.sv ----
/* Fabric logic that drains slice results, able to stall on command.
   Assumes the bench raises hold_i just after a rising edge. */
`timescale 1ns/100ps
module mas_fabric_sink (
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic valid_i,
  input wire logic [mas_pkg::C_W-1:0] data_i,
  output logic ready_o,
  output logic [mas_pkg::C_W-1:0] last_o
);
  // Ready drops while the bench asks for a stall
  assign ready_o = !hold_i;
  // Keep the last result taken, so the bench sees what left the buffer
  always_ff @(posedge clk_i) begin
    if (valid_i && ready_o) begin
      last_o <= data_i;
    end
  end
endmodule // mas_fabric_sink

// ---- mas_fifo.sv ----
/*
 * Small result buffer with valid/ready on both sides.
 * Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/100ps
module mas_fifo #(
  parameter int WIDTH = 58,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Elaboration check: power-of-two depth keeps pointer wrap simple
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("mas_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words
  logic [AW-1:0] wr_q;              // Write pointer
  logic [AW-1:0] rd_q;              // Read pointer
  logic [AW:0] cnt_q;               // Words held
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // mas_fifo

// ---- mas_pkg.sv ----
/*
 * Shared constants for the multiply-accumulate slice: operand widths,
 * lane layout of the dot-product mode, selector codes and reset values.
 * Assumes it is compiled before every other file of the slice.
 */
package mas_pkg;

  // ****************************************************************
  // Operand widths
  // ****************************************************************
  localparam int A_W = 34;      // First operand width
  localparam int A_MUL_W = 27;  // First operand bits used by multiplier
  localparam int B_W = 24;      // Second operand width
  localparam int C_W = 58;      // Third operand and result width
  localparam int D_W = 27;      // Fourth operand width
  localparam int FIELD_W = 12;  // Width of one carry field
  localparam int NFIELD = 4;    // Carry fields across the result

  // ****************************************************************
  // Dot-product lane layout
  // ****************************************************************
  localparam int LANE_A_W = 9;  // First operand lane width
  localparam int LANE_B_W = 8;  // Second operand lane width
  localparam int NLANE = 3;     // Lanes per operand

  // ****************************************************************
  // Control field widths and positions
  // ****************************************************************
  localparam int FUNC_W = 4;    // Second-stage function select width
  localparam int CSEL_W = 3;    // Carry source select width
  localparam int CFG_W = 5;     // Input configuration bits
  localparam int NEG_W = 3;     // Negate control width
  localparam int MUX_W = 9;     // Adder mux select width
  localparam int CFG_A1 = 0;    // Picks stage-1 first operand
  localparam int CFG_SUB = 3;   // Pre-adder subtracts
  localparam int CFG_B1 = 4;    // Picks stage-1 second operand

  // ****************************************************************
  // Carry source codes
  // ****************************************************************
  localparam logic [2:0] CS_FABRIC = 3'h0;   // Carry from logic
  localparam logic [2:0] CS_CASC_IN = 3'h2;  // Carry from previous slice
  localparam logic [2:0] CS_ROUND = 3'h4;    // Stored multiply carry
  localparam logic [2:0] CS_OWN = 3'h7;      // Own chain carry fed back

  // ****************************************************************
  // Reset values and result buffer depth
  // ****************************************************************
  localparam logic [0:0] RST_BIT = 1'h0;     // Reset registers clear; synchroniser flops and buffer storage are not reset
  localparam int FIFO_DEPTH = 4;             // Result buffer depth

endpackage : mas_pkg

// ---- mas_slice.sv ----
/*
 * One fixed-point multiply-accumulate slice: operand input registers,
 * cascade paths, pre-adder, multiplier with dot-product lanes, adder
 * mux, second-stage arithmetic and logic, carry fields and a result
 * buffer. Assumes fabric drives controls synchronously to CORE_CLK_I.
 */
`timescale 1ns/100ps
// Behaviour
// - Low 27 first bits multiply, all 34 concatenate
// - Dot mode: three 9-bit signed first lanes
// - Second operand feeds multiplier and concatenate low
// - Dot mode: three 8-bit signed second lanes
// - First operand cascade in selectable, out driven
// - Second operand cascade in selectable, out driven
// - Four-bit function select picks second-stage operation
// - 58-bit third operand reaches adder and logic
// - Carry source select, own chain carry fed back
// - Four carry bits: three from 12-bit fields, bit 3 from full width
// - First stage-1 register used for two stages
// - First stage-2 register used without config bit0
// - Second stage-1 register used for two stages
// - Second stage-2 register used without config bit4
// - Control enable loads mux and carry selects
// - Config enable also loads negate controls
// - Product enable loads product and round carry
// - All registers run on the one clock
// - Pre-adder adds to or subtracts from fourth operand
// - Config bits 0, 3 and 4 steer pre-adder and inputs
// - Negate bit0 in wide mode, all in dot
// - Nine-bit mux select drives W X Y Z
// - Common async reset only in async style
// - Mode picks 27x24 default or dot product
module mas_slice #(
  parameter int FIRST_OPERAND_STAGE_COUNT = 1,
  parameter int SECOND_OPERAND_STAGE_COUNT = 1,
  parameter bit FIRST_CASCADE_SELECT = 1'b0,
  parameter bit SECOND_CASCADE_SELECT = 1'b0,
  parameter bit PREADDER_OPERAND_CHOICE = 1'b0,
  parameter bit DOT_PRODUCT_MODE = 1'b0,
  parameter bit COMMON_ASYNC_RESET = 1'b0,
  parameter int FIFO_DEPTH = mas_pkg::FIFO_DEPTH
) (
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic COMMON_ASYNC_RESET_I,
  input wire logic [mas_pkg::A_W-1:0] FIRST_OPERAND_I,
  input wire logic [mas_pkg::B_W-1:0] SECOND_OPERAND_I,
  input wire logic [mas_pkg::C_W-1:0] THIRD_OPERAND_I,
  input wire logic [mas_pkg::D_W-1:0] FOURTH_OPERAND_I,
  input wire logic [mas_pkg::A_W-1:0] FIRST_OPERAND_CASCADE_IN_I,
  input wire logic [mas_pkg::B_W-1:0] SECOND_OPERAND_CASCADE_IN_I,
  input wire logic [mas_pkg::C_W-1:0] PRODUCT_CASCADE_IN_I,
  input wire logic CARRY_IN_I,
  input wire logic CARRY_CHAIN_IN_I,
  input wire logic [mas_pkg::FUNC_W-1:0] SECOND_STAGE_FUNCTION_SELECT_I,
  input wire logic [mas_pkg::CSEL_W-1:0] CARRY_SOURCE_SELECT_I,
  input wire logic [mas_pkg::CFG_W-1:0] INPUT_CONFIG_BITS_I,
  input wire logic [mas_pkg::NEG_W-1:0] NEGATE_I,
  input wire logic [mas_pkg::MUX_W-1:0] ADDER_MUX_SELECT_I,
  input wire logic FIRST_OPERAND_STAGE1_ENABLE_I,
  input wire logic FIRST_OPERAND_STAGE2_ENABLE_I,
  input wire logic SECOND_OPERAND_STAGE1_ENABLE_I,
  input wire logic SECOND_OPERAND_STAGE2_ENABLE_I,
  input wire logic FOURTH_OPERAND_ENABLE_I,
  input wire logic THIRD_OPERAND_ENABLE_I,
  input wire logic CONTROL_SELECT_ENABLE_I,
  input wire logic INPUT_CONFIG_ENABLE_I,
  input wire logic FUNCTION_ENABLE_I,
  input wire logic PRODUCT_PIPE_ENABLE_I,
  input wire logic RESULT_ENABLE_I,
  input wire logic RESULT_READY_I,
  output logic RESULT_STALL_O,
  output logic RESULT_VALID_O,
  output logic [mas_pkg::C_W-1:0] RESULT_O,
  output logic [mas_pkg::A_W-1:0] FIRST_OPERAND_CASCADE_OUT_O,
  output logic [mas_pkg::B_W-1:0] SECOND_OPERAND_CASCADE_OUT_O,
  output logic [mas_pkg::C_W-1:0] PRODUCT_CASCADE_OUT_O,
  output logic [mas_pkg::NFIELD-1:0] FIELD_CARRY_OUT_O,
  output logic CARRY_CHAIN_OUT_O
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (FIRST_OPERAND_STAGE_COUNT > 2 || SECOND_OPERAND_STAGE_COUNT > 2 ||
      FIRST_OPERAND_STAGE_COUNT < 0 || SECOND_OPERAND_STAGE_COUNT < 0)
  begin : g_chk
    $error("mas_slice operand stage counts must be 0, 1 or 2");
  end

  localparam int AW = mas_pkg::A_W;
  localparam int BW = mas_pkg::B_W;
  localparam int CW = mas_pkg::C_W;
  localparam int DW = mas_pkg::D_W;

  // ****************************************************************
  // Reset style
  // ****************************************************************
  // Async style samples the common reset through two flops so the
  // clear stays in this clock domain, at the cost of two cycles.
  logic ares_meta_q;  // First synchroniser flop
  logic ares_sync_q;  // Second synchroniser flop
  logic rst;          // Reset actually applied to registers

  // Common reset synchroniser
  always_ff @(posedge CORE_CLK_I) begin
    ares_meta_q <= COMMON_ASYNC_RESET_I;
    ares_sync_q <= ares_meta_q;
  end

  // Pick reset source by style
  assign rst = COMMON_ASYNC_RESET ? ares_sync_q : SYS_RST_I;

  // ****************************************************************
  // Operand input registers
  // ****************************************************************
  logic [AW-1:0] a_src;   // Direct or cascade first operand
  logic [BW-1:0] b_src;   // Direct or cascade second operand
  logic [AW-1:0] a1_q;    // First operand stage 1
  logic [AW-1:0] a2_q;    // First operand stage 2
  logic [BW-1:0] b1_q;    // Second operand stage 1
  logic [BW-1:0] b2_q;    // Second operand stage 2
  logic [DW-1:0] d_q;     // Fourth operand register
  logic [CW-1:0] c_q;     // Third operand register

  assign a_src = FIRST_CASCADE_SELECT ? FIRST_OPERAND_CASCADE_IN_I
                                      : FIRST_OPERAND_I;
  assign b_src = SECOND_CASCADE_SELECT ? SECOND_OPERAND_CASCADE_IN_I
                                       : SECOND_OPERAND_I;

  // First operand stages; stage 2 takes stage 1 when two are used
  always_ff @(posedge CORE_CLK_I) begin
    if (rst) begin
      a1_q <= '0;
      a2_q <= '0;
    end else begin
      if (FIRST_OPERAND_STAGE1_ENABLE_I) begin
        a1_q <= a_src;
      end
      if (FIRST_OPERAND_STAGE2_ENABLE_I) begin
        a2_q <= (FIRST_OPERAND_STAGE_COUNT == 2) ? a1_q : a_src;
      end
    end
  end

  // Second operand stages
  always_ff @(posedge CORE_CLK_I) begin
    if (rst) begin
      b1_q <= '0;
      b2_q <= '0;
    end else begin
      if (SECOND_OPERAND_STAGE1_ENABLE_I) begin
        b1_q <= b_src;
      end
      if (SECOND_OPERAND_STAGE2_ENABLE_I) begin
        b2_q <= (SECOND_OPERAND_STAGE_COUNT == 2) ? b1_q : b_src;
      end
    end
  end

  // Third and fourth operand registers
  always_ff @(posedge CORE_CLK_I) begin
    if (rst) begin
      c_q <= '0;
      d_q <= '0;
    end else begin
      if (THIRD_OPERAND_ENABLE_I) begin
        c_q <= THIRD_OPERAND_I;
      end
      if (FOURTH_OPERAND_ENABLE_I) begin
        d_q <= FOURTH_OPERAND_I;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [mas_pkg::CFG_W-1:0] cfg_q;    // Input configuration
  logic [mas_pkg::NEG_W-1:0] neg_q;    // Negate controls
  logic [mas_pkg::MUX_W-1:0] mux_q;    // Adder mux select
  logic [mas_pkg::CSEL_W-1:0] csel_q;  // Carry source select
  logic [mas_pkg::FUNC_W-1:0] func_q;  // Second-stage function

  // Config and negate share one enable
  always_ff @(posedge CORE_CLK_I) begin
    if (rst) begin
      cfg_q <= '0;
      neg_q <= '0;
    end else if (INPUT_CONFIG_ENABLE_I) begin
      cfg_q <= INPUT_CONFIG_BITS_I;
      neg_q <= NEGATE_I;
    end
  end

  // Mux and carry selects share the control enable
  always_ff @(posedge CORE_CLK_I) begin
    if (rst) begin
      mux_q <= '0;
      csel_q <= '0;
    end else if (CONTROL_SELECT_ENABLE_I) begin
      mux_q <= ADDER_MUX_SELECT_I;
      csel_q <= CARRY_SOURCE_SELECT_I;
    end
  end

  // Function select register
  always_ff @(posedge CORE_CLK_I) begin
    if (rst) begin
      func_q <= '0;
    end else if (FUNCTION_ENABLE_I) begin
      func_q <= SECOND_STAGE_FUNCTION_SELECT_I;
    end
  end

  // ****************************************************************
  // Operand choice, pre-adder and multiplier
  // ****************************************************************
  logic [AW-1:0] a_use;    // First operand seen by the datapath
  logic [BW-1:0] b_use;    // Second operand seen by the datapath
  logic [AW-1:0] a_mul;    // First operand for multiplier
  logic [BW-1:0] b_mul;    // Second operand for multiplier
  logic [DW-1:0] pre_sum;  // Pre-adder result
  logic signed [DW-1:0] mx;  // Multiplier first input
  logic signed [BW-1:0] my;  // Multiplier second input
  logic [CW-1:0] prod;     // Raw product

  assign a_use = (FIRST_OPERAND_STAGE_COUNT == 0) ? a_src : a2_q;
  assign b_use = (SECOND_OPERAND_STAGE_COUNT == 0) ? b_src : b2_q;
  // Config bit picks stage 1 for the multiplier only
  assign a_mul = (cfg_q[mas_pkg::CFG_A1] &&
                  FIRST_OPERAND_STAGE_COUNT != 0) ? a1_q : a_use;
  assign b_mul = (cfg_q[mas_pkg::CFG_B1] &&
                  SECOND_OPERAND_STAGE_COUNT != 0) ? b1_q : b_use;

  // Pre-adder: fourth operand plus or minus the chosen operand
  always_comb begin
    logic [DW-1:0] other;
    other = PREADDER_OPERAND_CHOICE ? DW'(signed'(b_mul))
                                    : a_mul[DW-1:0];
    pre_sum = cfg_q[mas_pkg::CFG_SUB] ? d_q - other
                                      : d_q + other;
  end

  assign mx = PREADDER_OPERAND_CHOICE ? a_mul[DW-1:0] : pre_sum;
  assign my = PREADDER_OPERAND_CHOICE ? pre_sum[BW-1:0] : b_mul;

  // Lane product of signed first and second lanes
  function automatic logic signed [CW-1:0] lane_mul(
    input logic [DW-1:0] a, input logic [BW-1:0] b, input int k);
    logic signed [mas_pkg::LANE_A_W-1:0] la;
    logic signed [mas_pkg::LANE_B_W-1:0] lb;
    la = signed'(a[k*mas_pkg::LANE_A_W +: mas_pkg::LANE_A_W]);
    lb = signed'(b[k*mas_pkg::LANE_B_W +: mas_pkg::LANE_B_W]);
    // Widen before multiplying so the lane product never wraps
    return CW'(la) * CW'(lb);
  endfunction

  // Wide or dot-product multiply with negation
  always_comb begin
    logic signed [CW-1:0] p;
    p = '0;
    if (DOT_PRODUCT_MODE) begin
      for (int k = 0; k < mas_pkg::NLANE; k++) begin
        p = neg_q[k] ? p - lane_mul(mx, my, k)
                     : p + lane_mul(mx, my, k);
      end
    end else begin
      p = CW'(mx) * CW'(my);
      if (neg_q[0]) begin
        p = -p;
      end
    end
    prod = p;
  end

  // ****************************************************************
  // Product pipe and round carry
  // ****************************************************************
  logic [CW-1:0] m_q;  // Post-multiply register
  logic rnd_q;         // Internal multiply carry

  // Both held by the product enable
  always_ff @(posedge CORE_CLK_I) begin
    if (rst) begin
      m_q <= '0;
      rnd_q <= 1'b0;
    end else if (PRODUCT_PIPE_ENABLE_I) begin
      m_q <= prod;
      rnd_q <= prod[CW-1];
    end
  end

  // ****************************************************************
  // Adder muxes, second stage and carries
  // ****************************************************************
  logic [CW-1:0] p_q;       // Result register
  logic [CW-1:0] wv, xv, yv, zv;
  logic cin;                // Selected carry
  logic [CW-1:0] sum;
  logic [mas_pkg::NFIELD-1:0] fcar;
  logic chain_q;            // Chain carry register
  logic [mas_pkg::NFIELD-1:0] fcar_q;

  // W/X/Y/Z selection from the mux select
  always_comb begin
    unique case (mux_q[1:0])
      2'h1: xv = m_q;
      2'h2: xv = p_q;
      2'h3: xv = {a_use, b_use};
      default: xv = '0;
    endcase
    unique case (mux_q[3:2])
      2'h3: yv = c_q;
      2'h2: yv = '1;
      default: yv = '0;
    endcase
    unique case (mux_q[6:4])
      3'h1: zv = PRODUCT_CASCADE_IN_I;
      3'h2: zv = p_q;
      3'h3: zv = c_q;
      default: zv = '0;
    endcase
    unique case (mux_q[8:7])
      2'h1: wv = p_q;
      2'h3: wv = c_q;
      default: wv = '0;
    endcase
  end

  // Carry source, own chain carry fed back
  always_comb begin
    unique case (csel_q)
      mas_pkg::CS_FABRIC: cin = CARRY_IN_I;
      mas_pkg::CS_CASC_IN: cin = CARRY_CHAIN_IN_I;
      mas_pkg::CS_ROUND: cin = rnd_q;
      mas_pkg::CS_OWN: cin = chain_q;
      default: cin = 1'b0;
    endcase
  end

  // Second-stage operation by function select
  always_comb begin
    logic [CW:0] t;
    t = '0;
    unique case (func_q)
      4'h0: t = (CW+1)'(zv) + xv + yv + wv + cin;
      4'h3: t = (CW+1)'(zv) - (xv + yv + wv + cin);
      4'h4: t = {1'b0, xv ^ zv};
      4'h5: t = {1'b0, xv ~^ zv};
      4'hc: t = {1'b0, xv & zv};
      4'he: t = {1'b0, xv | zv};
      default: t = {1'b0, ~zv};
    endcase
    sum = t[CW-1:0];
    // Field carries: each 12-bit field's carry out of its top
    for (int f = 0; f < mas_pkg::NFIELD - 1; f++) begin
      fcar[f] = t[(f+1)*mas_pkg::FIELD_W] ^ xv[(f+1)*mas_pkg::FIELD_W]
                ^ zv[(f+1)*mas_pkg::FIELD_W] ^ yv[(f+1)*mas_pkg::FIELD_W];
    end
    fcar[mas_pkg::NFIELD-1] = t[CW];  // Only bit 3 in full width
  end

  // Result, carries and chain
  always_ff @(posedge CORE_CLK_I) begin
    if (rst) begin
      p_q <= '0;
      fcar_q <= '0;
      chain_q <= 1'b0;
    end else if (RESULT_ENABLE_I && !RESULT_STALL_O) begin
      p_q <= sum;
      fcar_q <= fcar;
      chain_q <= fcar[mas_pkg::NFIELD-1];
    end
  end

  // Result valid marker for the buffer
  logic res_v_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (rst) begin
      res_v_q <= 1'b0;
    end else if (!RESULT_STALL_O) begin
      res_v_q <= RESULT_ENABLE_I;
    end
  end

  // ****************************************************************
  // Outputs and result buffer
  // ****************************************************************
  logic fifo_rdy;
  assign RESULT_STALL_O = res_v_q && !fifo_rdy;
  assign FIRST_OPERAND_CASCADE_OUT_O = a_use;
  assign SECOND_OPERAND_CASCADE_OUT_O = b_use;
  assign PRODUCT_CASCADE_OUT_O = p_q;
  assign FIELD_CARRY_OUT_O = fcar_q;
  assign CARRY_CHAIN_OUT_O = chain_q;

  mas_fifo #(
    .WIDTH(CW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CORE_CLK_I),
    .rst_i(rst),
    .in_valid_i(res_v_q),
    .in_ready_o(fifo_rdy),
    .in_data_i(p_q),
    .out_valid_o(RESULT_VALID_O),
    .out_ready_i(RESULT_READY_I),
    .out_data_o(RESULT_O)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_prod_hold: assert property (
    @(posedge CORE_CLK_I) disable iff (rst)
    !PRODUCT_PIPE_ENABLE_I |=> $stable(m_q) && $stable(rnd_q))
    else $error("product pipe changed without enable");
  a_ctrl_hold: assert property (
    @(posedge CORE_CLK_I) disable iff (rst)
    !CONTROL_SELECT_ENABLE_I |=> $stable(mux_q) && $stable(csel_q))
    else $error("selects changed without control enable");
  a_cfg_load: assert property (
    @(posedge CORE_CLK_I) disable iff (rst)
    INPUT_CONFIG_ENABLE_I |=> neg_q == $past(NEGATE_I))
    else $error("negate not loaded with config enable");
  a_a2_hold: assert property (
    @(posedge CORE_CLK_I) disable iff (rst)
    !FIRST_OPERAND_STAGE2_ENABLE_I |=> $stable(a2_q))
    else $error("first stage two changed while disabled");
  a_b1_load: assert property (
    @(posedge CORE_CLK_I) disable iff (rst)
    SECOND_OPERAND_STAGE1_ENABLE_I |=> b1_q == $past(b_src))
    else $error("second stage one not loaded");
  // With one stage the cascade out is the operand taken one edge ago
  a_casc_out: assert property (
    @(posedge CORE_CLK_I) disable iff (rst)
    FIRST_OPERAND_STAGE_COUNT == 1 && FIRST_OPERAND_STAGE2_ENABLE_I |=>
    FIRST_OPERAND_CASCADE_OUT_O == $past(a_src))
    else $error("first cascade out mismatch");
  a_chain_fb: assert property (
    @(posedge CORE_CLK_I) disable iff (rst)
    csel_q == mas_pkg::CS_OWN |-> cin == CARRY_CHAIN_OUT_O)
    else $error("own chain carry not fed back");
  a_b2_hold: assert property (
    @(posedge CORE_CLK_I) disable iff (rst)
    !SECOND_OPERAND_STAGE2_ENABLE_I |=> $stable(b2_q))
    else $error("second stage two changed while disabled");
endmodule // mas_slice

// ---- test_mult_accumulate_slice_ports.sv ----
/* Self-checking bench for the multiply-accumulate slice.
   Assumes the package, slice, buffer and sink are compiled first. */
`timescale 1ns/100ps
module test_mult_accumulate_slice_ports;
  // ****************************************************************
  // Nets named after the slice ports, joined by implicit names
  // ****************************************************************
  logic CORE_CLK_I, SYS_RST_I, COMMON_ASYNC_RESET_I, CARRY_IN_I;
  logic CARRY_CHAIN_IN_I, FIRST_OPERAND_STAGE1_ENABLE_I;
  logic FIRST_OPERAND_STAGE2_ENABLE_I, SECOND_OPERAND_STAGE1_ENABLE_I;
  logic SECOND_OPERAND_STAGE2_ENABLE_I, FOURTH_OPERAND_ENABLE_I;
  logic THIRD_OPERAND_ENABLE_I, CONTROL_SELECT_ENABLE_I;
  logic INPUT_CONFIG_ENABLE_I, FUNCTION_ENABLE_I, PRODUCT_PIPE_ENABLE_I;
  logic RESULT_ENABLE_I, RESULT_READY_I, RESULT_STALL_O, RESULT_VALID_O;
  logic CARRY_CHAIN_OUT_O, hold;
  logic [mas_pkg::A_W-1:0] FIRST_OPERAND_I, FIRST_OPERAND_CASCADE_IN_I;
  logic [mas_pkg::A_W-1:0] FIRST_OPERAND_CASCADE_OUT_O;
  logic [mas_pkg::B_W-1:0] SECOND_OPERAND_I, SECOND_OPERAND_CASCADE_IN_I;
  logic [mas_pkg::B_W-1:0] SECOND_OPERAND_CASCADE_OUT_O;
  logic [mas_pkg::C_W-1:0] THIRD_OPERAND_I, PRODUCT_CASCADE_IN_I;
  logic [mas_pkg::C_W-1:0] RESULT_O, PRODUCT_CASCADE_OUT_O, last;
  logic [mas_pkg::D_W-1:0] FOURTH_OPERAND_I;
  logic [3:0] SECOND_STAGE_FUNCTION_SELECT_I, FIELD_CARRY_OUT_O;
  logic [2:0] CARRY_SOURCE_SELECT_I, NEGATE_I;
  logic [4:0] INPUT_CONFIG_BITS_I;
  logic [8:0] ADDER_MUX_SELECT_I;
  int num_errors = 0;
  int n_checks = 0;

  mas_slice dut (.*);
  mas_fabric_sink sink (.clk_i(CORE_CLK_I), .hold_i(hold),
    .valid_i(RESULT_VALID_O), .data_i(RESULT_O),
    .ready_o(RESULT_READY_I), .last_o(last));

  // 250 MHz core clock
  initial begin
    CORE_CLK_I = 1'b0;
    forever #2 CORE_CLK_I = ~CORE_CLK_I;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK_I);
    #1;
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Compare at full result width; unknown bits match only unknown bits
  task automatic chk(input logic [57:0] got, input logic [57:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Bounded wait for the buffer output to show a word
  task automatic wait_valid;
    for (int i = 0; i < 20 && RESULT_VALID_O !== 1'b1; i++) tick(1);
    chk({57'h0, RESULT_VALID_O}, 58'h1);
    if (RESULT_VALID_O !== 1'b1) end_sim();
  endtask

  // One result of {first,second} + third, plus its top field carry
  task automatic t_add(input logic [33:0] a, input logic [23:0] b,
                       input logic [57:0] c, input logic cy);
    FIRST_OPERAND_I = a;
    SECOND_OPERAND_I = b;
    THIRD_OPERAND_I = c;
    ADDER_MUX_SELECT_I = 9'h033; // Z third, X concatenated pair
    tick(4);
    RESULT_ENABLE_I = 1'b1;
    tick(1);
    RESULT_ENABLE_I = 1'b0;
    wait_valid();
    chk(RESULT_O, {a, b} + c);
    chk({57'h0, FIELD_CARRY_OUT_O[3]}, {57'h0, cy});
    chk(PRODUCT_CASCADE_OUT_O, {a, b} + c);
    chk({57'h0, CARRY_CHAIN_OUT_O}, {57'h0, cy});
    tick(1);
    chk(last, {a, b} + c);
  endtask

  // Product through the pre-adder: (fourth +/- 3) * second, plus carry
  task automatic t_mul(input logic [26:0] d, input logic [23:0] b,
                       input logic [4:0] cfg, input logic [2:0] neg,
                       input logic [57:0] exp);
    FIRST_OPERAND_I = 34'h0_0000_0003;
    SECOND_OPERAND_I = b;
    FOURTH_OPERAND_I = d;
    INPUT_CONFIG_BITS_I = cfg;
    NEGATE_I = neg;
    ADDER_MUX_SELECT_I = 9'h001; // X product only
    tick(4);
    RESULT_ENABLE_I = 1'b1;
    tick(1);
    RESULT_ENABLE_I = 1'b0;
    wait_valid();
    chk(RESULT_O, exp);
    tick(1);
  endtask

  // A register whose enable is low keeps its word
  task automatic t_hold;
    FIRST_OPERAND_I = 34'h1_2345_6789;
    SECOND_OPERAND_I = 24'h65_4321;
    tick(2);
    chk(58'(FIRST_OPERAND_CASCADE_OUT_O), 58'h1_2345_6789);
    chk(58'(SECOND_OPERAND_CASCADE_OUT_O), 58'h65_4321);
    FIRST_OPERAND_STAGE2_ENABLE_I = 1'b0;
    FIRST_OPERAND_I = 34'h2_0000_0001;
    tick(3);
    chk(58'(FIRST_OPERAND_CASCADE_OUT_O), 58'h1_2345_6789);
    FIRST_OPERAND_STAGE2_ENABLE_I = 1'b1;
    tick(2);
    chk(58'(FIRST_OPERAND_CASCADE_OUT_O), 58'h2_0000_0001);
  endtask

  // Fill the buffer against a stalled sink, then drain it empty
  task automatic t_fill;
    hold = 1'b1;
    RESULT_ENABLE_I = 1'b1;
    for (int i = 0; i < 20 && RESULT_STALL_O !== 1'b1; i++) tick(1);
    chk({57'h0, RESULT_STALL_O}, 58'h1);
    if (RESULT_STALL_O !== 1'b1) end_sim();
    RESULT_ENABLE_I = 1'b0;
    hold = 1'b0;
    for (int i = 0; i < 20 && RESULT_VALID_O !== 1'b0; i++) tick(1);
    chk({57'h0, RESULT_VALID_O}, 58'h0);
    if (RESULT_VALID_O !== 1'b0) end_sim();
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {COMMON_ASYNC_RESET_I, CARRY_IN_I, CARRY_CHAIN_IN_I, hold} = 4'h0;
    {FIRST_OPERAND_STAGE1_ENABLE_I, FIRST_OPERAND_STAGE2_ENABLE_I} = 2'h3;
    {SECOND_OPERAND_STAGE1_ENABLE_I, SECOND_OPERAND_STAGE2_ENABLE_I} = 2'h3;
    {FOURTH_OPERAND_ENABLE_I, THIRD_OPERAND_ENABLE_I} = 2'h3;
    {CONTROL_SELECT_ENABLE_I, INPUT_CONFIG_ENABLE_I} = 2'h3;
    {FUNCTION_ENABLE_I, PRODUCT_PIPE_ENABLE_I, RESULT_ENABLE_I} = 3'h6;
    {FIRST_OPERAND_I, FIRST_OPERAND_CASCADE_IN_I} = 68'h0;
    {SECOND_OPERAND_I, SECOND_OPERAND_CASCADE_IN_I} = 48'h0;
    {THIRD_OPERAND_I, PRODUCT_CASCADE_IN_I} = 116'h0;
    FOURTH_OPERAND_I = 27'h000_0000;
    {SECOND_STAGE_FUNCTION_SELECT_I, CARRY_SOURCE_SELECT_I} = 7'h00;
    INPUT_CONFIG_BITS_I = 5'h00;
    NEGATE_I = 3'h0;
    ADDER_MUX_SELECT_I = 9'h000;
    SYS_RST_I = 1'b1;
    tick(16);
    SYS_RST_I = 1'b0;
    t_add(34'h2_AAAA_5555, 24'h12_3456, 58'h000_0000_0001_0001, 1'b0);
    t_add(34'h3_FFFF_FFFF, 24'hFF_FFFF, 58'h000_0000_0000_0001, 1'b1);
    // Own chain carry is 1 after the wrap above: (4+3)*(-5)+1
    CARRY_SOURCE_SELECT_I = 3'h7;
    t_mul(27'h000_0004, 24'hFF_FFFB, 5'h00, 3'h0,
          58'h3FF_FFFF_FFFF_FFDE);
    // Chain carry now 0; subtract and negate: -((4-3)*(-5))
    t_mul(27'h000_0004, 24'hFF_FFFB, 5'h08, 3'h1,
          58'h000_0000_0000_0005);
    t_hold();
    t_fill();
    end_sim();
  end
endmodule // test_mult_accumulate_slice_ports
